// [hdl/sofh_pkg.sv]
/*
  shared constants and carrier types of the safety output fault handler,
  plus the state type of the per-output latch timer that the handler instantiates.
  assumes a 10 MHz clock and that command and diagnosis inputs are
  produced by logic on that same clock.
*/
// Summary of operation
// - In single-channel mode a diagnosed fault forces only that output off and lights its red indicator steady.
// - Every newly detected fault is pushed into the error history and the block keeps running.
// - In dual-channel mode a fault on either output of a pair forces both outputs of the pair off.
// - For a dual-channel fault the faulty terminal lights steady red and its partner flashes red.
// - A command discrepancy in a dual-channel pair forces both off, lights both steady red and is logged.
// - A discrepancy is flagged whenever the pair's commands differ, and the pair turns on only when both are 1.
// - Pairs are an even output with the next odd one, and a pair drives on only while both are fault-free.
// - A raised fault stays asserted until the latch time has elapsed even if the cause goes away earlier.
// - The latch time is set from 0 to 65530 ms in 10 ms steps and is 1000 ms after reset.
// - A fault clears only when its cause is gone, its latch time has expired and its command is off, all three together.
// - In single-channel mode a fault on one output never forces another output off.
`default_nettype none
package sofh_pkg;
  localparam int NOUT           = 8;
  localparam int NPAIR          = NOUT / 2;
  localparam int LT_W           = 13;
  localparam int PRE_W          = 17;
  localparam int BLINK_W        = 5;
  localparam int CLK_HZ         = 10_000_000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int LATCH_MAX_MS   = 65530;
  localparam int LATCH_RST_MS   = 1000;
  localparam logic [LT_W-1:0] LATCH_MAX_TICKS = LT_W'(LATCH_MAX_MS / TICK_MS);
  localparam logic [LT_W-1:0] LATCH_RST_TICKS = LT_W'(LATCH_RST_MS / TICK_MS);
  localparam int BLINK_MS       = 250;
  localparam logic [BLINK_W-1:0] BLINK_TICKS = BLINK_W'(BLINK_MS / TICK_MS - 1);

  typedef struct packed {
    logic [2:0] idx;
    logic       disc;
  } sofh_hist_t;

  typedef struct packed {
    logic [PRE_W-1:0]   pre;
    logic [BLINK_W-1:0] blink_cnt;
    logic               blink;
    logic [LT_W-1:0]    latch_cfg;
    logic [NPAIR-1:0]   mode;
    logic [NOUT-1:0]    diag;
    logic [NOUT-1:0]    disc;
    logic [NOUT-1:0]    pend;
    logic [NOUT-1:0]    drive;
    logic [NOUT-1:0]    red;
    logic [NOUT-1:0]    flash;
    logic [NOUT-1:0]    fault;
    logic               hist_valid;
    sofh_hist_t         hist;
  } sofh_state_t;

  typedef struct packed {
    logic [LT_W-1:0] cnt;
  } sofh_tmr_t;
endpackage
`default_nettype wire

// [hdl/sofh_latch_timer.sv]
/*
  latch timer for one output: counts down in 10 ms ticks.
  assumes tick is a one-cycle pulse from the handler's prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
module sofh_latch_timer
  import sofh_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  ce,
  input  wire logic                  rst_b,
  input  wire logic                  load,
  input  wire logic                  tick,
  input  wire logic [sofh_pkg::LT_W-1:0] load_val,
  output logic                       expired
);
  import sofh_pkg::*;

  sofh_tmr_t s_r;
  sofh_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      // reload holds the count full while the cause persists
      if (load) begin
        s_nxt.cnt = load_val;
      end else if (tick && s_r.cnt != '0) begin
        s_nxt.cnt = s_r.cnt - LT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = (s_r.cnt == '0);
endmodule
`default_nettype wire

// [hdl/sofh_handler.sv]
/*
  fault reaction for eight safety outputs: forcing, indicators,
  fault latching and error history hand-off.
  assumes cmd, diag_fault, dual_mode and the config strobe come from
  logic on this clock; the history consumer takes every hist_valid cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sofh_handler
  import sofh_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = sofh_pkg::TICK_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       ce,
  input  wire logic                       rst_b,
  input  wire logic [sofh_pkg::NOUT-1:0]  cmd,
  input  wire logic [sofh_pkg::NOUT-1:0]  diag_fault,
  input  wire logic [sofh_pkg::NPAIR-1:0] dual_mode,
  input  wire logic                       cfg_wr,
  input  wire logic [sofh_pkg::LT_W-1:0]  cfg_latch_ticks,
  output logic [sofh_pkg::NOUT-1:0]       out_drive,
  output logic [sofh_pkg::NOUT-1:0]       led_red,
  output logic [sofh_pkg::NOUT-1:0]       led_flash,
  output logic [sofh_pkg::NOUT-1:0]       fault_state,
  output logic [sofh_pkg::LT_W-1:0]       latch_cfg,
  output logic                            hist_valid,
  output sofh_pkg::sofh_hist_t            hist_entry
);
  import sofh_pkg::*;

  sofh_state_t     s_r;
  sofh_state_t     s_nxt;
  logic            tick_w;
  logic [NOUT-1:0] expired_w;
  logic [NOUT-1:0] disc_cause;
  logic [NOUT-1:0] cause;
  logic [NOUT-1:0] fault_w;
  logic [NOUT-1:0] new_fault;

  assign tick_w  = (s_r.pre == PRE_W'(TICK_CYCLES - 1));
  assign fault_w = s_r.diag | s_r.disc;

  // discrepancy is checked per pair: even output with the next odd one
  always_comb begin
    disc_cause = '0;
    for (int p = 0; p < NPAIR; p++) begin
      disc_cause[2*p]   = dual_mode[p] & (cmd[2*p] ^ cmd[2*p+1]);
      disc_cause[2*p+1] = dual_mode[p] & (cmd[2*p] ^ cmd[2*p+1]);
    end
  end

  assign cause     = diag_fault | disc_cause;
  assign new_fault = cause & ~fault_w;

  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_tmr
      sofh_latch_timer u_tmr (
        .clock    (clock),
        .ce       (ce),
        .rst_b    (rst_b),
        .load     (cause[gi]),
        .tick     (tick_w),
        .load_val (s_r.latch_cfg),
        .expired  (expired_w[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [NOUT-1:0] clr;
    logic [NOUT-1:0] pend;
    logic [NOUT-1:0] f;
    logic            found;
    clr   = '0;
    pend  = '0;
    f     = '0;
    found = 1'b0;
    s_nxt = s_r;
    if (ce) begin
      s_nxt.pre = tick_w ? '0 : s_r.pre + PRE_W'(1);
      if (tick_w) begin
        s_nxt.blink_cnt = (s_r.blink_cnt == BLINK_TICKS) ? '0 : s_r.blink_cnt + BLINK_W'(1);
        if (s_r.blink_cnt == BLINK_TICKS) begin
          s_nxt.blink = ~s_r.blink;
        end
      end
      if (cfg_wr) begin
        // out-of-range settings saturate instead of wrapping to a short latch
        s_nxt.latch_cfg = (cfg_latch_ticks > LATCH_MAX_TICKS) ? LATCH_MAX_TICKS
                                                              : cfg_latch_ticks;
      end
      s_nxt.mode = dual_mode;
      // all three recovery conditions together; a live cause also wins over clear
      clr = ~cause & expired_w & ~cmd;
      s_nxt.diag = (s_r.diag & ~clr) | diag_fault;
      s_nxt.disc = (s_r.disc & ~clr) | disc_cause;
      // history: queue new faults, hand out the lowest index each cycle
      pend = s_r.pend | new_fault;
      s_nxt.hist_valid = 1'b0;
      for (int i = 0; i < NOUT; i++) begin
        if (pend[i] && !found) begin
          found             = 1'b1;
          pend[i]           = 1'b0;
          s_nxt.hist_valid  = 1'b1;
          s_nxt.hist.idx    = 3'(i);
          s_nxt.hist.disc   = s_nxt.disc[i] & ~s_nxt.diag[i];
        end
      end
      s_nxt.pend = pend;
      f = s_nxt.diag | s_nxt.disc;
      // the fault port gets a flop of its own instead of an or of two flops
      s_nxt.fault = f;
      s_nxt.red = f;
      for (int p = 0; p < NPAIR; p++) begin
        if (dual_mode[p]) begin
          s_nxt.drive[2*p]   = cmd[2*p] & cmd[2*p+1] & ~f[2*p] & ~f[2*p+1];
          s_nxt.drive[2*p+1] = cmd[2*p] & cmd[2*p+1] & ~f[2*p] & ~f[2*p+1];
          s_nxt.flash[2*p]   = s_nxt.diag[2*p+1] & ~f[2*p] & s_nxt.blink;
          s_nxt.flash[2*p+1] = s_nxt.diag[2*p] & ~f[2*p+1] & s_nxt.blink;
        end else begin
          s_nxt.drive[2*p]   = cmd[2*p] & ~f[2*p];
          s_nxt.drive[2*p+1] = cmd[2*p+1] & ~f[2*p+1];
          s_nxt.flash[2*p]   = 1'b0;
          s_nxt.flash[2*p+1] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r           <= '0;
      s_r.latch_cfg <= LATCH_RST_TICKS;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_drive   = s_r.drive;
  assign led_red     = s_r.red;
  assign led_flash   = s_r.flash;
  assign fault_state = s_r.fault;
  assign latch_cfg   = s_r.latch_cfg;
  assign hist_valid  = s_r.hist_valid;
  assign hist_entry  = s_r.hist;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // checks judge the registered copies; many also sample cmd, cause, new_fault or dual_mode as triggers
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_chk
      faulted_off_a : assert property (fault_w[gi] |-> !out_drive[gi])
        else $error("faulted output still driven");
      cmd_off_a : assert property (ce && !cmd[gi] |=> !out_drive[gi])
        else $error("output driven without its command");
      red_fault_a : assert property (led_red[gi] == fault_w[gi])
        else $error("steady red does not follow the latched fault");
      diag_red_a : assert property (s_r.diag[gi] |-> led_red[gi] && !led_flash[gi])
        else $error("diagnosed output not steady red");
      latch_hold_a : assert property (ce && fault_w[gi] && !expired_w[gi] |=> fault_w[gi])
        else $error("fault dropped before latch expiry");
      cmd_hold_a : assert property (ce && fault_w[gi] && cmd[gi] |=> fault_w[gi])
        else $error("fault cleared while command active");
      clear_release_a : assert property (
        ce && fault_w[gi] && !cause[gi] && expired_w[gi] && !cmd[gi] |=> !fault_w[gi])
        else $error("fault held after all recovery conditions met");
      single_free_a : assert property (
        ce && !dual_mode[gi/2] && cmd[gi] && !cause[gi] && !fault_w[gi] |=> out_drive[gi])
        else $error("single output blocked without own fault");
      history_a : assert property (
        ce && new_fault[gi] |=> s_r.pend[gi] || (hist_valid && hist_entry.idx == 3'(gi)))
        else $error("new fault not queued for history");
    end

    // a pair's verdict is shared by both of its members
    for (gi = 0; gi < NPAIR; gi++) begin : g_pair
      pair_off_a : assert property (
        s_r.mode[gi] && (fault_w[2*gi] || fault_w[2*gi+1]) |-> out_drive[2*gi+1:2*gi] == 2'b00)
        else $error("pair driven with a faulted member");
      pair_on_a : assert property (
        ce && dual_mode[gi] && cmd[2*gi] && cmd[2*gi+1] && !cause[2*gi] && !cause[2*gi+1]
        && !fault_w[2*gi] && !fault_w[2*gi+1] |=> out_drive[2*gi+1:2*gi] == 2'b11)
        else $error("healthy pair with both commands not driven");
      discrepancy_a : assert property (
        ce && dual_mode[gi] && (cmd[2*gi] != cmd[2*gi+1])
        |=> s_r.disc[2*gi] && s_r.disc[2*gi+1] && led_red[2*gi] && led_red[2*gi+1])
        else $error("discrepancy not latched on both members");
      flash_even_a : assert property (
        led_flash[2*gi] == (s_r.mode[gi] && s_r.diag[2*gi+1] && !fault_w[2*gi] && s_r.blink))
        else $error("even output flash does not follow partner fault");
      flash_odd_a : assert property (
        led_flash[2*gi+1] == (s_r.mode[gi] && s_r.diag[2*gi] && !fault_w[2*gi+1] && s_r.blink))
        else $error("odd output flash does not follow partner fault");
    end
  endgenerate

  reset_cfg_a : assert property (@(posedge clock) disable iff (1'b0)
    !rst_b |=> latch_cfg == LATCH_RST_TICKS)
    else $error("latch time not at reset value");
  cfg_load_a : assert property (
    ce && cfg_wr && cfg_latch_ticks <= LATCH_MAX_TICKS |=> latch_cfg == $past(cfg_latch_ticks))
    else $error("latch time not taken from the write");
  cfg_clamp_a : assert property (
    ce && cfg_wr && cfg_latch_ticks > LATCH_MAX_TICKS |=> latch_cfg == LATCH_MAX_TICKS)
    else $error("oversized latch time not saturated");
  hist_disc_a : assert property (
    hist_valid |-> hist_entry.disc == (s_r.disc[hist_entry.idx] && !s_r.diag[hist_entry.idx]))
    else $error("history entry kind does not match the latched fault");

  // main scenarios the bench is expected to reach
  single_fault_c : cover property (!s_r.mode[1] && s_r.diag[3] && out_drive[2]);
  partner_flash_c : cover property (s_r.mode[1] && s_r.diag[2] && led_flash[3]);
  recover_c : cover property (fault_w[4] ##1 !fault_w[4]);
  disc_c : cover property (s_r.disc[4] && s_r.disc[5]);
  clamp_c : cover property (ce && cfg_wr && cfg_latch_ticks > LATCH_MAX_TICKS);
endmodule
`default_nettype wire

// [bench/sofh_user_model.sv]
/*
  model of the user logic program that commands the eight outputs.
  assumes the handler clock; obey low models a program that keeps
  commanding a faulted output.
*/
`timescale 1ns/1ps
`default_nettype none
module sofh_user_model
  import sofh_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       obey,
  input  wire logic [sofh_pkg::NOUT-1:0]  want,
  input  wire logic [sofh_pkg::NOUT-1:0]  fault_state,
  input  wire logic [sofh_pkg::NPAIR-1:0] dual_mode,
  output var logic  [sofh_pkg::NOUT-1:0]  cmd
);
  logic [NOUT-1:0] drop;

  // a dual pair is dropped as a whole, otherwise the program itself
  // would raise a discrepancy on the healthy partner
  always_comb begin
    drop = fault_state;
    for (int p = 0; p < NPAIR; p++) begin
      if (dual_mode[p] && (fault_state[2*p] || fault_state[2*p+1])) begin
        drop[2*p+1 -: 2] = 2'b11;
      end
    end
  end

  // one cycle late, as a real program scan would be
  always @(posedge clock) begin
    cmd <= #1 obey ? (want & ~drop) : want;
  end
endmodule
`default_nettype wire

// [bench/sofh_handler_tb_top.sv]
/*
  self-checking bench of the fault handler, run with a 10-cycle tick.
  assumes sofh_pkg, sofh_handler and sofh_user_model.
*/
`timescale 1ns/1ps
`default_nettype none
module sofh_handler_tb_top;
  import sofh_pkg::*;
  localparam int TICK = 10;
  localparam int LAT  = 3;
  logic             clock, rst_b, obey, cfg_wr, hist_valid;
  logic [NOUT-1:0]  want, cmd, diag_fault, out_drive, led_red, led_flash, fault_state, w;
  logic [NPAIR-1:0] dual_mode;
  logic [LT_W-1:0]  cfg_latch_ticks, latch_cfg;
  sofh_hist_t       hist_entry;
  sofh_hist_t       exp_q[$];
  int               errors, total_checks, seed, n;
  logic [31:0]      r;

  sofh_handler #(.TICK_CYCLES(TICK)) uut (.clock(clock), .ce(1'b1), .rst_b(rst_b),
    .cmd(cmd), .diag_fault(diag_fault), .dual_mode(dual_mode), .cfg_wr(cfg_wr),
    .cfg_latch_ticks(cfg_latch_ticks), .out_drive(out_drive), .led_red(led_red),
    .led_flash(led_flash), .fault_state(fault_state), .latch_cfg(latch_cfg),
    .hist_valid(hist_valid), .hist_entry(hist_entry));
  sofh_user_model prog (.clock(clock), .obey(obey), .want(want),
    .fault_state(fault_state), .dual_mode(dual_mode), .cmd(cmd));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // sel 0 watches fault_state, sel 1 the flashing indicator
  task automatic wait_sig(input int sel, input int idx, input logic val);
    n = 0;
    while (((sel != 0) ? led_flash[idx] : fault_state[idx]) !== val && n < 1000) begin
      step(1);
      n++;
    end
    if (n >= 1000) begin
      errors++;
      complete_run();
    end
  endtask

  always @(posedge clock) begin
    if (hist_valid === 1'b1) begin
      if (exp_q.size() > 0) chk(hist_entry, exp_q.pop_front());
      else chk(hist_entry, 16'hxxxx);
    end
  end

  initial begin
    seed = 61620;
    errors = 0;
    total_checks = 0;
    rst_b = 1'b0;
    obey = 1'b1;
    want = '0;
    diag_fault = '0;
    dual_mode = '0;
    cfg_wr = 1'b0;
    cfg_latch_ticks = '0;
    step(6);
    rst_b = 1'b1;
    step(1);
    chk(latch_cfg, LATCH_RST_TICKS);
    cfg_wr = 1'b1;
    cfg_latch_ticks = 13'h1fff;
    step(1);
    cfg_wr = 1'b0;
    step(1);
    chk(latch_cfg, LATCH_MAX_TICKS);
    cfg_wr = 1'b1;
    cfg_latch_ticks = 13'(LAT);
    step(1);
    cfg_wr = 1'b0;
    want = 8'hff;
    step(3);
    chk(out_drive, 8'hff);
    // a one-cycle cause must still hold for the latch time
    diag_fault[3] = 1'b1;
    exp_q.push_back('{3'd3, 1'b0});
    step(1);
    diag_fault[3] = 1'b0;
    chk(out_drive, 8'hf7);
    chk(led_red, 8'h08);
    wait_sig(0, 3, 1'b0);
    chk(16'(n >= (LAT - 1) * TICK && n <= (LAT + 1) * TICK + 5), 16'h1);
    // a program that keeps the command on pins the fault
    obey = 1'b0;
    diag_fault[5] = 1'b1;
    exp_q.push_back('{3'd5, 1'b0});
    step(1);
    diag_fault[5] = 1'b0;
    step(LAT * TICK + 20);
    chk(fault_state[5], 1'b1);
    obey = 1'b1;
    wait_sig(0, 5, 1'b0);
    chk(16'(n <= 4), 16'h1);
    dual_mode = 4'h2;
    step(2);
    diag_fault[2] = 1'b1;
    exp_q.push_back('{3'd2, 1'b0});
    step(1);
    chk(out_drive, 8'hf3);
    chk(led_red[2], 1'b1);
    wait_sig(1, 3, 1'b1);
    chk(led_red[3], 1'b0);
    diag_fault[2] = 1'b0;
    wait_sig(0, 2, 1'b0);
    wait_sig(0, 3, 1'b0);
    step(3);
    chk(out_drive, 8'hff);
    dual_mode = 4'h4;
    step(2);
    want = 8'hef;
    exp_q.push_back('{3'd4, 1'b1});
    exp_q.push_back('{3'd5, 1'b1});
    step(3);
    chk(fault_state[5:4], 2'b11);
    chk(led_red[5:4], 2'b11);
    chk(out_drive[5:4], 2'b00);
    want = 8'hff;
    wait_sig(0, 4, 1'b0);
    wait_sig(0, 5, 1'b0);
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      want = '0;
      step(2);
      dual_mode = r[11:8];
      step(1);
      w = r[7:0];
      for (int p = 0; p < NPAIR; p++) if (r[8+p]) w[2*p+1] = w[2*p];
      want = w;
      step(3);
      chk(out_drive, w);
    end
    step(20);
    chk(16'(exp_q.size()), 16'h0);
    complete_run();
  end
endmodule
`default_nettype wire
